// *** logic/e1_defs.svh ***
// register indices, field positions, reset values and vector codes of the framer control block
`ifndef E1_DEFS_SVH
`define E1_DEFS_SVH
`define IDX_INSERT 6'h17
`define IDX_DETECT 6'h18
`define IDX_CMPMASK 6'h19
`define IDX_CTRL 6'h1a
`define IDX_MASK0 6'h1b
`define IDX_MASK1 6'h1c
`define IDX_VECTOR 6'h20
`define REG_RESET 8'h00
`define CTRL_USED 8'hdc
`define MASK1_USED 8'hfd
`define CTL_DELAY 7
`define CTL_SUSPEND 6
`define CTL_TXCCS 4
`define CTL_RSIG 3
`define CTL_BSRC 2
`define M0_SYNC 7
`define M0_RAI 6
`define M0_AIS 5
`define M0_AIS16 4
`define M0_LOS 3
`define M0_FER 2
`define M0_WRAP 1
`define M0_SLIP 0
`define M1_EBIT 7
`define M1_CRC 6
`define M1_CEF 5
`define M1_BPV 4
`define M1_RCR 3
`define M1_BER 2
`define M1_SIG 0
`define VB_SYNC 7
`define VB_ALARM 6
`define VB_ERROR 5
`define VB_OVFL 4
`define VB_SPARE 3
`define VB_SLIP 2
`define VB_DATA 1
`define VB_SIG 0
`define VEC_NONE 8'h00
`endif

// *** logic/e1_pkg.sv ***
// types carried between the framer control block and its neighbours
package e1_pkg;
   typedef struct packed {
      logic frameSyncLoss;
      logic remoteAlarm;
      logic allOnesAlarm;
      logic slot16Alarm;
      logic signalLoss;
      logic alignError;
      logic violationWrap;
      logic controlledSlip;
      logic bufferFault;
      logic remoteCrcError;
      logic localCrcError;
      logic doubleAlignError;
      logic violation;
      logic remoteAlarmCrcCount;
      logic signallingChange;
   } event_type;
   typedef struct packed {
      logic [7:0] data;
      logic valid;
      logic select;
   } slot_type;
   typedef struct packed {
      logic oneFrameBuffer;
      logic controlledSlipEnable;
      logic txCcsMode;
      logic registerSignalling;
      logic bitErrorFromCompare;
      logic slipStatus;
   } ctrl_type;
endpackage

// *** logic/e1_interrupt_mask_and_code_match.sv ***
// code insert/detect, control word and interrupt masking of an E1 framer
//
// Behaviour
// - transmit insert pattern in selected slots
// - per-slot insert select picks transmit slots
// - compare detect pattern on selected receive slots
// - match raises maskable data interrupt
// - compare mask bit one includes position
// - delay set: one frame, no slips
// - delay clear: two frames, controlled slips
// - suspend floats request, ignores sources
// - mode bit: zero CAS, one CCS
// - signalling from registers or serial stream
// - bit error source: alignment or compare
// - mask word zero: zero enables source
// - frame sync loss gives vector 80
// - alarms and signal loss give 40
// - alignment error gives vector 20
// - violation counter wrap gives 10
// - controlled slip gives vector 04
// - mask word one: one enables source
// - crc, violation, bit errors give 20
// - signalling change gives vector 01
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ns
`include "e1_defs.svh"

module e1_interrupt_mask_and_code_match #(
   parameter int ADDR_W = 8
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   input wire e1_pkg::slot_type txSlotIn,
   output logic [7:0] txSlotOut,
   output logic txSlotOutValid,
   input wire e1_pkg::slot_type rxSlotIn,
   input wire logic [6:0] fasBitErrors,
   input wire logic compareBitError,
   input wire logic serialBackplaneMode,
   input wire logic dataIrqEnable,
   input wire e1_pkg::event_type events,
   output e1_pkg::ctrl_type ctrlOut,
   output logic bitErrorPulse,
   output logic dataMatchPulse,
   output logic irqN,
   output logic irqOe
);

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   logic [7:0] insertPattern;
   logic [7:0] detectPattern;
   logic [7:0] detectCompareMask;
   logic [7:0] irqSignallingBertCtrl;
   logic [7:0] interruptMaskZero;
   logic [7:0] interruptMaskOne;
   logic [7:0] pending;
   logic [7:0] vectorNow;
   logic [7:0] readData;
   logic [5:0] regIndex;
   logic request;
   logic writeLow;
   logic readVector;

   assign regIndex = adr_i[7:2];
   assign request = cyc_i & stb_i & ~ack_o;
   assign writeLow = request & we_i & sel_i[0];
   assign readVector = request & ~we_i & (regIndex == `IDX_VECTOR);

   always_comb begin
      if (regIndex == `IDX_INSERT) begin
         readData = insertPattern;
      end else if (regIndex == `IDX_DETECT) begin
         readData = detectPattern;
      end else if (regIndex == `IDX_CMPMASK) begin
         readData = detectCompareMask;
      end else if (regIndex == `IDX_CTRL) begin
         readData = irqSignallingBertCtrl;
      end else if (regIndex == `IDX_MASK0) begin
         readData = interruptMaskZero;
      end else if (regIndex == `IDX_MASK1) begin
         readData = interruptMaskOne;
      end else if (regIndex == `IDX_VECTOR) begin
         readData = vectorNow;
      end else begin
         readData = `VEC_NONE;
      end
   end

   // one wait-free answer; unmapped reads return zero, unmapped writes vanish
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= request;
         dat_o <= request ? {24'h00_0000, readData} : 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         insertPattern <= `REG_RESET;
         detectPattern <= `REG_RESET;
         detectCompareMask <= `REG_RESET;
         irqSignallingBertCtrl <= `REG_RESET;
         interruptMaskZero <= `REG_RESET;
         interruptMaskOne <= `REG_RESET;
      end else if (writeLow) begin
         if (regIndex == `IDX_INSERT) begin
            insertPattern <= dat_i[7:0];
         end else if (regIndex == `IDX_DETECT) begin
            detectPattern <= dat_i[7:0];
         end else if (regIndex == `IDX_CMPMASK) begin
            detectCompareMask <= dat_i[7:0];
         end else if (regIndex == `IDX_CTRL) begin
            irqSignallingBertCtrl <= dat_i[7:0] & `CTRL_USED;
         end else if (regIndex == `IDX_MASK0) begin
            interruptMaskZero <= dat_i[7:0];
         end else if (regIndex == `IDX_MASK1) begin
            interruptMaskOne <= dat_i[7:0] & `MASK1_USED;
         end
      end
   end

   // ----------------------------------------------------------------
   // control word
   // ----------------------------------------------------------------
   logic receiveDelaySelect;
   logic irqSuspend;
   logic slipEvent;
   logic bitErrorEvent;

   assign receiveDelaySelect = irqSignallingBertCtrl[`CTL_DELAY];
   assign irqSuspend = irqSignallingBertCtrl[`CTL_SUSPEND];
   // slips are only counted as controlled slips with the two-frame buffer
   assign slipEvent = events.controlledSlip & ~receiveDelaySelect;
   assign bitErrorEvent = irqSignallingBertCtrl[`CTL_BSRC] ? compareBitError
                                                          : |fasBitErrors;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctrlOut <= '0;
      end else begin
         ctrlOut.oneFrameBuffer <= receiveDelaySelect;
         ctrlOut.controlledSlipEnable <= ~receiveDelaySelect;
         ctrlOut.txCcsMode <= irqSignallingBertCtrl[`CTL_TXCCS];
         // the backplane mode has no register-signalling path
         ctrlOut.registerSignalling <= irqSignallingBertCtrl[`CTL_RSIG]
                                       & ~serialBackplaneMode;
         ctrlOut.bitErrorFromCompare <= irqSignallingBertCtrl[`CTL_BSRC];
         ctrlOut.slipStatus <= receiveDelaySelect ? events.bufferFault
                                                  : slipEvent;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         bitErrorPulse <= 1'b0;
      end else begin
         bitErrorPulse <= bitErrorEvent;
      end
   end

   // ----------------------------------------------------------------
   // code insertion and detection
   // ----------------------------------------------------------------
   logic slotMatch;

   assign slotMatch = rxSlotIn.valid & rxSlotIn.select
                      & (((rxSlotIn.data ^ detectPattern) & detectCompareMask) == 8'h00);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         txSlotOut <= 8'h00;
         txSlotOutValid <= 1'b0;
      end else begin
         txSlotOutValid <= txSlotIn.valid;
         if (txSlotIn.valid) begin
            txSlotOut <= txSlotIn.select ? insertPattern : txSlotIn.data;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         dataMatchPulse <= 1'b0;
      end else begin
         dataMatchPulse <= slotMatch;
      end
   end

   // ----------------------------------------------------------------
   // interrupt sources and vector
   // ----------------------------------------------------------------
   logic [7:0] enableZero;
   logic [7:0] enableOne;
   logic [7:0] groupSet;
   logic [7:0] groupClear;

   assign enableZero = ~interruptMaskZero;
   assign enableOne = interruptMaskOne;

   always_comb begin
      groupSet = 8'h00;
      groupSet[`VB_SYNC] = events.frameSyncLoss & enableZero[`M0_SYNC];
      groupSet[`VB_ALARM] = (events.remoteAlarm & enableZero[`M0_RAI])
                            | (events.allOnesAlarm & enableZero[`M0_AIS])
                            | (events.slot16Alarm & enableZero[`M0_AIS16])
                            | (events.signalLoss & enableZero[`M0_LOS]);
      groupSet[`VB_ERROR] = (events.alignError & enableZero[`M0_FER])
                            | (events.remoteCrcError & enableOne[`M1_EBIT])
                            | (events.localCrcError & enableOne[`M1_CRC])
                            | (events.doubleAlignError & enableOne[`M1_CEF])
                            | (events.violation & enableOne[`M1_BPV])
                            | (events.remoteAlarmCrcCount & enableOne[`M1_RCR])
                            | (bitErrorEvent & enableOne[`M1_BER]);
      groupSet[`VB_OVFL] = events.violationWrap & enableZero[`M0_WRAP];
      groupSet[`VB_SLIP] = slipEvent & enableZero[`M0_SLIP];
      groupSet[`VB_DATA] = dataMatchPulse & dataIrqEnable;
      groupSet[`VB_SIG] = events.signallingChange & enableOne[`M1_SIG];
      if (irqSuspend) begin
         groupSet = 8'h00;
      end
   end

   // highest pending code wins; lower codes stay queued for the next read
   always_comb begin
      vectorNow = `VEC_NONE;
      for (int i = 0; i < 8; i++) begin
         if (pending[i]) begin
            vectorNow = 8'h01 << i;
         end
      end
   end

   // reading the vector acknowledges the group it shows
   assign groupClear = readVector ? vectorNow : 8'h00;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pending <= 8'h00;
      end else begin
         // a new event in the clearing cycle survives
         pending <= (pending & ~groupClear) | groupSet;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         irqN <= 1'b1;
         irqOe <= 1'b0;
      end else begin
         irqN <= ~(|pending);
         irqOe <= ~irqSuspend;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   insert_slot_data_a: assert property (
      txSlotIn.valid && txSlotIn.select |=> txSlotOut == $past(insertPattern))
      else $error("selected transmit slot lacks insert pattern");
   pass_slot_data_a: assert property (
      txSlotIn.valid && !txSlotIn.select |=> txSlotOut == $past(txSlotIn.data))
      else $error("unselected transmit slot altered");
   masked_match_a: assert property (
      rxSlotIn.valid && rxSlotIn.select && detectCompareMask == 8'h00 |=> dataMatchPulse)
      else $error("fully masked compare did not match");
   data_irq_a: assert property (
      dataMatchPulse && dataIrqEnable && !irqSuspend |=> pending[`VB_DATA])
      else $error("data match not pending");
   slip_buffer_a: assert property (
      $past(nrst) |-> ctrlOut.oneFrameBuffer == !ctrlOut.controlledSlipEnable)
      else $error("buffer depth and slip enable disagree");
   suspend_float_a: assert property (
      irqSuspend |=> !irqOe && pending == ($past(pending) & ~$past(groupClear)))
      else $error("suspended interrupt still active");
   backplane_sig_a: assert property (
      serialBackplaneMode |=> !ctrlOut.registerSignalling)
      else $error("register signalling in backplane mode");
   sync_vector_a: assert property (
      events.frameSyncLoss && !interruptMaskZero[`M0_SYNC] && !irqSuspend
      |=> vectorNow == 8'h80 ##1 !irqN)
      else $error("sync loss vector wrong");
   mask_one_a: assert property (
      !irqSuspend && events.signallingChange && !interruptMaskOne[`M1_SIG]
      && !pending[`VB_SIG] |=> !pending[`VB_SIG])
      else $error("masked signalling change set pending");
   irq_level_a: assert property (
      pending != 8'h00 |=> !irqN)
      else $error("request high with event pending");
   insert_hold_a: assert property (
      !txSlotIn.valid |=> $stable(txSlotOut))
      else $error("transmit slot changed without a slot");
   tx_valid_a: assert property (
      txSlotIn.valid |=> txSlotOutValid)
      else $error("transmit slot valid missing");
   tx_idle_a: assert property (
      !txSlotIn.valid |=> !txSlotOutValid)
      else $error("transmit slot valid without a slot");
   detect_unselected_a: assert property (
      !(rxSlotIn.valid && rxSlotIn.select) |=> !dataMatchPulse)
      else $error("match on unselected receive slot");
   detect_mismatch_a: assert property (
      rxSlotIn.valid && rxSlotIn.select
      && ((rxSlotIn.data ^ detectPattern) & detectCompareMask) != 8'h00 |=> !dataMatchPulse)
      else $error("match despite compared bit difference");
   data_masked_a: assert property (
      dataMatchPulse && !dataIrqEnable && !pending[`VB_DATA] |=> !pending[`VB_DATA])
      else $error("disabled data match set pending");
   one_frame_a: assert property (
      receiveDelaySelect |=> ctrlOut.oneFrameBuffer
      && ctrlOut.slipStatus == $past(events.bufferFault))
      else $error("one frame buffer status wrong");
   no_slip_irq_a: assert property (
      receiveDelaySelect && !pending[`VB_SLIP] |=> !pending[`VB_SLIP])
      else $error("slip interrupt with one frame buffer");
   two_frame_a: assert property (
      nrst && !receiveDelaySelect |=> ctrlOut.controlledSlipEnable
      && ctrlOut.slipStatus == $past(events.controlledSlip))
      else $error("two frame buffer status wrong");
   tx_mode_a: assert property (
      nrst |=> ctrlOut.txCcsMode == $past(irqSignallingBertCtrl[`CTL_TXCCS]))
      else $error("transmit signalling mode wrong");
   reg_sig_a: assert property (
      nrst && !serialBackplaneMode
      |=> ctrlOut.registerSignalling == $past(irqSignallingBertCtrl[`CTL_RSIG]))
      else $error("signalling source select wrong");
   fas_source_a: assert property (
      nrst && !irqSignallingBertCtrl[`CTL_BSRC] |=> bitErrorPulse == $past(|fasBitErrors))
      else $error("alignment bit error not counted");
   cmp_source_a: assert property (
      irqSignallingBertCtrl[`CTL_BSRC]
      |=> bitErrorPulse == $past(compareBitError) && ctrlOut.bitErrorFromCompare)
      else $error("compare bit error not counted");
   mask_zero_a: assert property (
      !irqSuspend && events.frameSyncLoss && interruptMaskZero[`M0_SYNC]
      && !pending[`VB_SYNC] |=> !pending[`VB_SYNC])
      else $error("masked sync loss set pending");
   alarm_vector_a: assert property (
      !irqSuspend && events.signalLoss && !interruptMaskZero[`M0_LOS] |=> pending[`VB_ALARM])
      else $error("signal loss not pending");
   align_vector_a: assert property (
      !irqSuspend && events.alignError && !interruptMaskZero[`M0_FER] |=> pending[`VB_ERROR])
      else $error("alignment error not pending");
   wrap_vector_a: assert property (
      !irqSuspend && events.violationWrap && !interruptMaskZero[`M0_WRAP] |=> pending[`VB_OVFL])
      else $error("violation wrap not pending");
   slip_vector_a: assert property (
      !irqSuspend && events.controlledSlip && !receiveDelaySelect
      && !interruptMaskZero[`M0_SLIP] |=> pending[`VB_SLIP])
      else $error("controlled slip not pending");
   crc_vector_a: assert property (
      !irqSuspend && events.localCrcError && interruptMaskOne[`M1_CRC] |=> pending[`VB_ERROR])
      else $error("local crc error not pending");
   sig_vector_a: assert property (
      !irqSuspend && events.signallingChange && interruptMaskOne[`M1_SIG] |=> pending[`VB_SIG])
      else $error("signalling change not pending");
   drive_enable_a: assert property (
      nrst && !irqSuspend |=> irqOe)
      else $error("request pin not driven");
   spare_idle_a: assert property (
      !pending[`VB_SPARE])
      else $error("unused vector group pending");
   irq_release_a: assert property (
      pending == 8'h00 |=> irqN)
      else $error("request low with nothing pending");
   vector_clear_a: assert property (
      readVector && groupSet == 8'h00 |=> (pending & $past(vectorNow)) == 8'h00)
      else $error("read group still pending");
   highest_code_a: assert property (
      pending[`VB_SYNC] |-> vectorNow == 8'h80)
      else $error("sync loss not shown first");

endmodule

// *** sim/slot_source.sv ***
// line-side model that hands one time slot at a time to the framer block
`timescale 1ns/1ns
module slot_source (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic go,
   input wire logic [7:0] data,
   input wire logic sel,
   output e1_pkg::slot_type slot
);
   // ------------------------------------------------------------
   // slot strobe
   // ------------------------------------------------------------
   // between slots the byte keeps toggling, so stale data never passes for a slot
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         slot <= '0;
      end else if (go) begin
         slot <= '{data: data, valid: 1'b1, select: sel};
      end else begin
         slot <= '{data: ~slot.data, valid: 1'b0, select: 1'b0};
      end
   end
endmodule

// *** sim/testbench.sv ***
// self-checking bench of the framer control block
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
   // ------------------------------------------------------------
   // stimulus and tables
   // ------------------------------------------------------------
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [3:0] sel = 4'hf;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic go = 1'b0;
   logic [7:0] sd = 8'h00;
   logic ss = 1'b0;
   logic [6:0] fas = 7'h00;
   logic cmpErr = 1'b0;
   logic bpl = 1'b0;
   logic den = 1'b1;
   logic [7:0] cmpMask = 8'hf0;
   e1_pkg::event_type ev = '0;
   logic [31:0] dat;
   logic ack, txV, bitErr, match, irqN, irqOe;
   logic [7:0] txOut;
   logic [7:0] rd;
   e1_pkg::slot_type slotIn;
   e1_pkg::ctrl_type ctrl;
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   // address, byte written, byte read back
   logic [23:0] regRows [8] = '{24'h5c3c3c, 24'h60a5a5, 24'h64f0f0, 24'h68ffdc,
      24'h6cffff, 24'h70fffd, 24'h74ff00, 24'h80ff00};
   // event pulses, vector they leave
   logic [22:0] evRows [14] = '{23'h400080, 23'h200040, 23'h100040, 23'h080040,
      23'h040040, 23'h020020, 23'h010010, 23'h008004, 23'h002020, 23'h001020,
      23'h000820, 23'h000420, 23'h000220, 23'h000101};
   // slot byte, select
   logic [8:0] slotRows [4] = '{9'h14b, 9'h15f, 9'h16b, 9'h14a};

   e1_interrupt_mask_and_code_match e1_interrupt_mask_and_code_match_inst (
      .core_clk(core_clk), .nrst(nrst), .adr_i(adr), .dat_i(wdat), .dat_o(dat),
      .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
      .txSlotIn(slotIn), .txSlotOut(txOut), .txSlotOutValid(txV), .rxSlotIn(slotIn),
      .fasBitErrors(fas), .compareBitError(cmpErr), .serialBackplaneMode(bpl),
      .dataIrqEnable(den), .events(ev), .ctrlOut(ctrl), .bitErrorPulse(bitErr),
      .dataMatchPulse(match), .irqN(irqN), .irqOe(irqOe));
   // one stream feeds both directions, so insert and detect see the same byte
   slot_source slot_source_inst (.core_clk(core_clk), .nrst(nrst), .go(go),
      .data(sd), .sel(ss), .slot(slotIn));

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic bus(input logic [7:0] a, input logic w, input logic [3:0] s,
         input logic [7:0] d, output logic [7:0] q);
      @(posedge core_clk);
      adr <= a;
      we <= w;
      sel <= s;
      wdat <= {24'h000000, d};
      cyc <= 1'b1;
      stb <= 1'b1;
      do @(posedge core_clk); while (ack !== 1'b1);
      q = dat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(a, 1'b1, 4'hf, d, rd);
   endtask
   task automatic pulse(input logic [14:0] e, input logic [6:0] f, input logic c);
      @(posedge core_clk);
      ev <= e;
      fas <= f;
      cmpErr <= c;
      @(posedge core_clk);
      ev <= '0;
      fas <= 7'h00;
      cmpErr <= 1'b0;
      #1;
   endtask
   // request level, vector read, then request released once the group is read
   task automatic vec(input logic [7:0] code);
      repeat (2) @(posedge core_clk);
      #1 `CHK(irqN, code == 8'h00)
      bus(8'h80, 1'b0, 4'hf, 8'h00, rd);
      `CHK(rd, code)
      repeat (2) @(posedge core_clk);
      #1 `CHK(irqN, 1'b1)
   endtask
   task automatic slot(input logic [7:0] d, input logic s);
      @(posedge core_clk);
      go <= 1'b1;
      sd <= d;
      ss <= s;
      @(posedge core_clk);
      go <= 1'b0;
      @(posedge core_clk);
      #1 `CHK(txOut, s ? 8'h3c : d)
      `CHK(txV, 1'b1)
      `CHK(match, s & (((d ^ 8'ha5) & cmpMask) == 8'h00))
   endtask
   task automatic end_of_test();
      if (num_errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // clock, timeout, sequence
   // ------------------------------------------------------------
   initial begin
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 4000) begin
         num_errors++;
         end_of_test();
      end
   end
   initial begin
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      #1 `CHK(irqOe, 1'b1)
      `CHK(irqN, 1'b1)
      foreach (regRows[i]) begin
         bus(regRows[i][23:16], 1'b0, 4'hf, 8'h00, rd);
         `CHK(rd, 8'h00)
      end
      foreach (regRows[i]) begin
         wr(regRows[i][23:16], regRows[i][15:8]);
         bus(regRows[i][23:16], 1'b0, 4'hf, 8'h00, rd);
         `CHK(rd, regRows[i][7:0])
      end
      #1 `CHK(ctrl, 6'h2e)
      `CHK(irqOe, 1'b0)
      @(posedge core_clk);
      bpl <= 1'b1;
      pulse(15'h0040, 7'h00, 1'b0);
      `CHK(ctrl.slipStatus, 1'b1)
      `CHK(ctrl.registerSignalling, 1'b0)
      pulse(15'h0000, 7'h7f, 1'b0);
      `CHK(bitErr, 1'b0)
      pulse(15'h0000, 7'h00, 1'b1);
      `CHK(bitErr, 1'b1)
      wr(8'h68, 8'h00);
      pulse(15'h0000, 7'h00, 1'b1);
      `CHK(bitErr, 1'b0)
      pulse(15'h0000, 7'h40, 1'b0);
      `CHK(bitErr, 1'b1)
      repeat (2) @(posedge core_clk);
      vec(8'h20);
      wr(8'h70, 8'h00);
      pulse(15'h7fff, 7'h00, 1'b0);
      vec(8'h00);
      wr(8'h6c, 8'h00);
      wr(8'h70, 8'hfd);
      foreach (evRows[i]) begin
         pulse(evRows[i][22:8], 7'h00, 1'b0);
         vec(evRows[i][7:0]);
      end
      foreach (slotRows[i]) begin
         slot(slotRows[i][8:1], slotRows[i][0]);
      end
      wr(8'h64, 8'h00);
      cmpMask = 8'h00;
      slot(8'h0f, 1'b1);
      vec(8'h02);
      @(posedge core_clk);
      den <= 1'b0;
      slot(8'h0f, 1'b1);
      vec(8'h00);
      wr(8'h68, 8'h40);
      pulse(15'h4000, 7'h00, 1'b0);
      `CHK(irqOe, 1'b0)
      vec(8'h00);
      wr(8'h68, 8'h80);
      pulse(15'h0080, 7'h00, 1'b0);
      vec(8'h00);
      bus(8'h5c, 1'b1, 4'he, 8'h11, rd);
      bus(8'h5c, 1'b0, 4'hf, 8'h00, rd);
      `CHK(rd, 8'h3c)
      end_of_test();
   end
endmodule
